// file: irq_pend_regs.svh
// Register indices, field positions and reset values of the pending-interrupt bank.
// Overview of operation
// RL1 - Read returns one for each posted interrupt.
// RL2 - Enable clear: written zero clears posted interrupt.
// RL3 - Zero written where nothing posted does nothing.
// RL4 - Enable set: written one posts an interrupt.
// RL5 - Bits: endpoints three..zero, frame start, reset, timers.
// RL6 - Enable clear: written one is ignored.
// RL7 - Enable set: written zero is ignored.
// RL8 - Reset leaves all eight positions unposted.
`ifndef IRQ_PEND_REGS_SVH
`define IRQ_PEND_REGS_SVH

// Register indices; the byte address is four times the index.
`define PEND_CLR_IDX 8'hdb
`define POST_EN_IDX 8'hdc

`define PEND_RESET 8'h00
`define POST_EN_RESET 1'b0
`define POST_EN_BIT 0

`define EP_THREE_BIT 7
`define EP_ZERO_BIT 4
`define SOF_BIT 3
`define BUS_RESET_BIT 2
`define SECOND_COUNTER_BIT 1
`define FIRST_COUNTER_BIT 0

// Reads insert this many wait states before the data phase completes.
`define READ_WAIT_STATES 1

`endif

// file: irq_pend_pkg.sv
// Types shared by the pending-interrupt bank.
package irq_pend_pkg;

    // Bit 7 down to bit 0 of the pending register.
    typedef struct packed {
        logic usb_ep_three_irq;
        logic usb_ep_two_irq;
        logic usb_ep_one_irq;
        logic usb_ep_zero_irq;
        logic usb_sof_irq;
        logic usb_bus_reset_irq;
        logic second_counter_irq;
        logic first_counter_irq;
    } irq_bank_s;

    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_write = 2'b01,
        st_read_wait = 2'b10
    } bus_state_e;

endpackage

// file: pend_bits.sv
// Eight posted-interrupt flip-flops with set-over-clear update.
`include "irq_pend_regs.svh"

module pend_bits
    import irq_pend_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic [7:0] set_vec,
    input wire logic [7:0] clr_vec,
    output logic [7:0] pend
);

    logic [7:0] pend_q;
    logic [7:0] pend_d;

    // A source event in the same cycle as a clearing write must not be lost, so set wins.
    always_comb begin
        pend_d = (pend_q & ~clr_vec) | set_vec; // RL2 RL3 RL4
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_q <= `PEND_RESET; // RL8
        end else if (ce) begin
            pend_q <= pend_d;
        end
    end

    assign pend = pend_q;

endmodule

// file: irq_pend_clr_bank.sv
// AHB-Lite slave holding the posted-interrupt register and the software post enable.
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`include "irq_pend_regs.svh"

module irq_pend_clr_bank
    import irq_pend_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire irq_bank_s src_irq,
    output irq_bank_s irq_pending,
    output logic software_irq_post_enable
);

    bus_state_e state_q;
    bus_state_e state_d;
    logic [31:0] addr_q;
    logic [31:0] addr_d;
    logic [31:0] hrdata_q;
    logic [31:0] hrdata_d;
    logic hreadyout_q;
    logic hreadyout_d;
    logic rd_ret_q;
    logic rd_ret_d;
    logic hresp_q;
    logic post_en_q;
    logic post_en_d;
    logic [7:0] pend_q;
    logic [7:0] set_vec;
    logic [7:0] clr_vec;
    logic [7:0] src_vec;
    logic accept;
    logic wr_data_phase;
    logic wr_fire_clr;
    logic wr_fire_en;
    logic fire_clr_ce;

    function automatic logic addr_hit(input logic [31:0] a, input logic [7:0] idx);
        return a == {22'h0, idx, 2'b00};
    endfunction

    // Unmapped addresses read as zero.
    function automatic logic [31:0] reg_read(input logic [31:0] a, input logic [7:0] pend,
                                             input logic en);
        logic [31:0] r;
        r = 32'h00000000;
        if (addr_hit(a, `PEND_CLR_IDX)) begin
            r = {24'h000000, pend}; // RL1
        end else if (addr_hit(a, `POST_EN_IDX)) begin
            r = {31'h0, en};
        end
        return r;
    endfunction

    assign src_vec = src_irq; // RL5
    assign accept = hsel & htrans[1] & hready;
    assign wr_data_phase = (state_q == st_write) & hreadyout_q;
    assign wr_fire_clr = wr_data_phase & addr_hit(addr_q, `PEND_CLR_IDX);
    assign wr_fire_en = wr_data_phase & addr_hit(addr_q, `POST_EN_IDX);
    assign fire_clr_ce = wr_fire_clr & ce;

    // Reads take one wait state so that the returned word is a registered snapshot
    // that already includes a write completed just before.
    always_comb begin
        state_d = state_q;
        addr_d = addr_q;
        hrdata_d = hrdata_q;
        hreadyout_d = hreadyout_q;
        rd_ret_d = 1'b0;
        unique case (state_q)
            st_read_wait: begin
                state_d = st_idle;
                hreadyout_d = 1'b1;
                hrdata_d = reg_read(addr_q, pend_q, post_en_q); // RL1
                rd_ret_d = addr_hit(addr_q, `PEND_CLR_IDX);
            end
            st_idle, st_write: begin
                if (accept) begin
                    addr_d = haddr;
                    state_d = hwrite ? st_write : st_read_wait;
                    hreadyout_d = hwrite;
                end else begin
                    state_d = st_idle;
                    hreadyout_d = 1'b1;
                end
            end
            default: begin
                state_d = st_idle;
                hreadyout_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= st_idle;
            addr_q <= 32'h00000000;
            hrdata_q <= 32'h00000000;
            hreadyout_q <= 1'b1;
            rd_ret_q <= 1'b0;
            hresp_q <= 1'b0;
        end else if (ce) begin
            state_q <= state_d;
            addr_q <= addr_d;
            hrdata_q <= hrdata_d;
            hreadyout_q <= hreadyout_d;
            rd_ret_q <= rd_ret_d;
            hresp_q <= 1'b0;
        end
    end

    // Written ones never clear and written zeros never post; which of the two acts
    // depends only on the enable.
    always_comb begin
        clr_vec = 8'h00;
        set_vec = src_vec;
        post_en_d = post_en_q;
        if (wr_fire_clr && !post_en_q) begin
            clr_vec = ~hwdata[7:0]; // RL2 RL6
        end
        if (wr_fire_clr && post_en_q) begin
            set_vec = src_vec | hwdata[7:0]; // RL4 RL7
        end
        if (wr_fire_en) begin
            post_en_d = hwdata[`POST_EN_BIT];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            post_en_q <= `POST_EN_RESET;
        end else if (ce) begin
            post_en_q <= post_en_d;
        end
    end

    pend_bits u_pend_bits (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .set_vec(set_vec),
        .clr_vec(clr_vec),
        .pend(pend_q)
    );

    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = hresp_q;
    assign irq_pending = pend_q;
    assign software_irq_post_enable = post_en_q;

    a_read_shows_pending: assert property ( // RL1
        @(posedge hclk) disable iff (!hresetn || !ce)
        rd_ret_q |-> hrdata_q == {24'h000000, $past(pend_q)})
        else $error("read data differs from posted interrupts");

    a_zero_clears_bit: assert property ( // RL2
        @(posedge hclk) disable iff (!hresetn || !ce)
        fire_clr_ce && !post_en_q |=>
            (pend_q & ~$past(hwdata[7:0]) & ~$past(src_vec)) == 8'h00)
        else $error("written zero did not clear posted interrupt");

    a_clear_no_post: assert property ( // RL3
        @(posedge hclk) disable iff (!hresetn || !ce)
        fire_clr_ce && !post_en_q |=> (pend_q & ~$past(pend_q) & ~$past(src_vec)) == 8'h00)
        else $error("clearing write posted an interrupt");

    a_one_posts_bit: assert property ( // RL4
        @(posedge hclk) disable iff (!hresetn || !ce)
        fire_clr_ce && post_en_q |=> (pend_q & $past(hwdata[7:0])) == $past(hwdata[7:0]))
        else $error("written one did not post interrupt");

    a_map_ep_three: assert property ( // RL5
        @(posedge hclk) disable iff (!hresetn || !ce)
        src_irq.usb_ep_three_irq |=> irq_pending[`EP_THREE_BIT] ##1 1'b1)
        else $error("endpoint three event not posted at bit seven");

    a_map_first_counter: assert property ( // RL5
        @(posedge hclk) disable iff (!hresetn || !ce)
        src_irq.first_counter_irq && !src_irq.second_counter_irq && !wr_fire_clr |=>
            irq_pending[`FIRST_COUNTER_BIT] && ($past(pend_q[`SECOND_COUNTER_BIT]) ||
            !irq_pending[`SECOND_COUNTER_BIT]))
        else $error("first counter event landed on wrong bit");

    a_one_ignored_clear: assert property ( // RL6
        @(posedge hclk) disable iff (!hresetn || !ce)
        fire_clr_ce && !post_en_q |=> ($past(pend_q) & $past(hwdata[7:0]) & ~pend_q) == 8'h00)
        else $error("written one changed a bit while enable clear");

    a_zero_ignored_set: assert property ( // RL7
        @(posedge hclk) disable iff (!hresetn || !ce)
        fire_clr_ce && post_en_q |=> (pend_q & $past(pend_q)) == $past(pend_q))
        else $error("posted interrupt cleared while enable set");

    a_reset_unposted: assert property ( // RL8
        @(posedge hclk) $rose(hresetn) |-> irq_pending == 8'h00 && !software_irq_post_enable)
        else $error("pending bits not zero after reset");

    a_read_wait_state: assert property (
        @(posedge hclk) disable iff (!hresetn || !ce)
        state_q == st_idle && accept && !hwrite |=> !hreadyout_q ##1 hreadyout_q)
        else $error("read did not complete after one wait state");

endmodule

// file: irq_pend_clr_bank_test.sv
// Self-checking bench for the pending-interrupt clear bank over AHB-Lite.
`include "irq_pend_regs.svh"

module irq_pend_clr_bank_test
    import irq_pend_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] PEND_ADDR = {22'h0, `PEND_CLR_IDX, 2'b00};
    localparam logic [31:0] EN_ADDR = {22'h0, `POST_EN_IDX, 2'b00};
    logic hclk, hresetn, ce, hsel, hwrite, hready, hreadyout, hresp, post_en;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    irq_bank_s src_irq, irq_pending;
    int miscompares = 0;
    int comparisons = 0;
    int seed = 88;
    int pend_m = 0;
    int en_m = 0;
    int v;

    assign hready = hreadyout;

    irq_pend_clr_bank DUT (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .src_irq(src_irq), .irq_pending(irq_pending), .software_irq_post_enable(post_en));

    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    // Values are taken at the falling edge so that they are the ones the rising edge sees.
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        logic r;
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        do begin
            @(negedge hclk);
            r = hready;
            @(posedge hclk);
        end while (!r);
        htrans <= 2'b00;
        hwdata <= d;
        do begin
            @(negedge hclk);
            r = hready;
            rd = hrdata;
            @(posedge hclk);
        end while (!r);
    endtask

    task automatic check(input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: expected %h, got %h", $time, exp, got);
        end
    endtask

    task automatic wr_pend(input int d);
        bus(1'b1, PEND_ADDR, d);
        pend_m = en_m[0] ? (pend_m | (d & 'hff)) : (pend_m & d & 'hff);
    endtask

    task automatic wr_en(input int d);
        bus(1'b1, EN_ADDR, d);
        en_m = d & 1;
    endtask

    task automatic pulse(input logic [7:0] s);
        src_irq <= s;
        @(posedge hclk);
        src_irq <= 8'h00;
        pend_m = pend_m | s;
    endtask

    task automatic verify();
        bus(1'b0, PEND_ADDR, 32'h0);
        check(pend_m, rd);
        check(pend_m, {24'h0, irq_pending});
        check(en_m, {31'h0, post_en});
        check(32'h0, {31'h0, hresp});
    endtask

    task automatic summarize();
        $display("comparisons %0d, miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        miscompares++;
        summarize();
    end

    initial begin
        hresetn = 1'b0;
        ce = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        src_irq = 8'h00;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        verify();
        for (int i = 0; i < 8; i++) begin
            pulse(8'h01 << i);
            verify();
        end
        wr_pend(32'h0000005a);
        verify();
        wr_pend(32'h0);
        wr_pend(32'h0);
        verify();
        wr_pend(32'hff);
        verify();
        pulse(irq_bank_s'{usb_ep_three_irq: 1'b1, default: 1'b0});
        pend_m = 32'h1 << `EP_THREE_BIT;
        verify();
        wr_en(1);
        wr_pend(32'h24);
        verify();
        wr_pend(32'h0);
        verify();
        // An unmapped word must neither hold data nor disturb the bank.
        bus(1'b1, 32'h3fc, 32'hffffffff);
        bus(1'b0, 32'h3fc, 32'h0);
        check(32'h0, rd);
        verify();
        repeat (40) begin
            v = $random(seed);
            if (v[0]) begin
                pulse(v[15:8]);
            end
            wr_en(v[1]);
            wr_pend(v[23:16]);
            verify();
        end
        // With the clock enable low a source event must be lost, so start from an empty bank.
        wr_en(0);
        wr_pend(32'h0);
        ce <= 1'b0;
        src_irq <= 8'hff;
        @(posedge hclk);
        ce <= 1'b1;
        src_irq <= 8'h00;
        verify();
        // A reset in mid-run must drop posted bits and the post enable.
        wr_en(1);
        wr_pend(32'h81);
        verify();
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        pend_m = 0;
        en_m = 0;
        verify();
        summarize();
    end
endmodule
